// >>> inc/vendor_cfg_pkg.sv
// package: offsets, field positions, reset values and carriers for the vendor config bank
package vendor_cfg_pkg;

    // register offsets in configuration space (byte addresses)
    localparam logic [7:0] off_tl_tuning      = 8'h8c;
    localparam logic [7:0] off_phy_lane_delta = 8'h90;
    localparam logic [7:0] off_phy_margin_eq  = 8'h94;
    localparam logic [7:0] off_opmode_refclk  = 8'h98;
    localparam logic [7:0] off_subsys_cap     = 8'hb0;
    localparam logic [7:0] off_subsys_codes   = 8'hb4;
    localparam logic [7:0] off_general_pin    = 8'hb8;

    // transaction-layer tuning field positions
    localparam int tl_order_dis_bit    = 6;
    localparam int tl_overpass_dis_bit = 5;
    localparam int tl_retry_lsb        = 8;
    localparam int tl_port_dis_bit     = 10;
    localparam int tl_reset_sel_bit    = 11;
    localparam logic [31:0] tl_write_mask = 32'h0000_0060;
    localparam logic [31:0] tl_reset_val  = 32'h0079_0010;

    // physical-layer parameter resets
    localparam logic [6:0]  lane_mode_reset   = 7'h00;
    localparam logic [16:0] delta_reset       = 17'h0_0001;
    localparam logic [15:0] tx_margin_reset   = 16'h116b;
    localparam logic [7:0]  eq_reset_upstream = 8'h86;
    localparam logic [7:0]  eq_reset_down     = 8'h00;

    // reference clock buffer control
    localparam int          refclk_master_bit = 20;
    localparam logic [3:0]  refclk_pair_reset = 4'hf;

    // capability header
    localparam logic [7:0]  cap_id_subsys     = 8'h0d;
    localparam logic [7:0]  cap_next_reset    = 8'hc0;

    // subsystem code resets; a default load replaces them in any real system
    localparam logic [15:0] vendor_code_reset = 16'h1d2e; // arbitrary value
    localparam logic [15:0] device_code_reset = 16'h2e3f; // arbitrary value

    // general pin control fields
    localparam int pin_in_bit   = 0;
    localparam int pin_dir_bit  = 1;
    localparam int pin_data_bit = 2;

    // config space request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } cfg_req_type;

    // default overrides from management bus or eeprom autoload
    typedef struct packed {
        logic        load;
        logic [31:0] tl_tuning;
        logic [6:0]  lane_mode;
        logic [16:0] delta;
        logic [15:0] tx_margin;
        logic [7:0]  equaliser;
        logic [15:0] op_mode;
        logic [3:0]  refclk_pairs;
        logic        refclk_master;
        logic [7:0]  cap_next;
        logic [15:0] vendor_code;
        logic [15:0] device_code;
    } default_load_type;

endpackage : vendor_cfg_pkg

// >>> hw/switch_port_vendor_config_regs.sv
// vendor-specific configuration register bank of one switch port
// Functional notes
// - defaults replaceable by management bus or eeprom
// - master refclk bit: 0 enable, 1 disable
// - four per-pair refclk enables, reset enabled
// - master disable resets from powerdown strap
// - capability id reads fixed subsystem id 0Dh
// - next pointer resets to serial-bus capability
// - read-only 16-bit subsystem vendor code
// - read-only 16-bit subsystem device code, upper
// - pin zero input bit shows pin level
// - pin zero direction bit, reset input
// - data driven only when output, reset 0
// - pin control register upstream port only
// - ordering-disable bit kills relaxed ordering, reset 0
// - port-disable bit disables the port
// - reset select honoured on upstream only
// - two-bit rate change retry count, reset 00
// - operation mode word layout from mode inputs
// - equaliser upstream only, 86h else 00h
// - seven-bit lane mode, separate global delta
`timescale 1ns/1ps
`default_nettype none
module switch_port_vendor_config_regs
    import vendor_cfg_pkg::*;
#(
    parameter bit is_upstream = 1'b1
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // configuration space access
    input  wire cfg_req_type       cfg_req,
    output logic [31:0]            cfg_rdata,
    output logic                   cfg_ack,
    // default override path
    input  wire default_load_type  dflt,
    // straps and mode indications
    input  wire logic              refclk_powerdown_strap,
    input  wire logic              test_shift_mode,
    input  wire logic [2:0]        package_variant_select,
    input  wire logic              physical_layer_variant,
    input  wire logic              debug_mode,
    input  wire logic              fast_sim_mode,
    input  wire logic              quiescent_current_test_n,
    input  wire logic              serial_rom_skip,
    // general pin zero, three-signal form
    input  wire logic              gpin0_in,
    output logic                   gpin0_out,
    output logic                   gpin0_oe_n,
    // controls toward the port
    output logic                   relaxed_order_off,
    output logic                   port_disabled,
    output logic                   reset_select,
    output logic [1:0]             rate_change_retry_select,
    output logic [3:0]             refclk_output_pairs,
    output logic [6:0]             lane_mode,
    output logic [7:0]             multilane_receive_equaliser
);

    // software-visible register state
    logic [31:0] tl_q;
    logic [6:0]  lane_q;
    logic [16:0] delta_q;
    logic [15:0] margin_q;
    logic [7:0]  eq_q;
    logic [15:0] opmode_q;

    // reference clock buffer state
    logic [3:0]  pairs_q;
    logic        master_q;
    logic        strap_taken_q;
    logic        master_eff;

    // capability and identification state
    logic [7:0]  next_q;
    logic [15:0] vendor_q;
    logic [15:0] device_q;

    // general pin zero state
    logic        pin_dir_q;
    logic        pin_data_q;
    logic        pin_in_q;

    // assembled read words, one per implemented offset
    logic [31:0] word_tl;
    logic [31:0] word_lane_delta;
    logic [31:0] word_margin_eq;
    logic [31:0] word_opmode;
    logic [31:0] word_cap;
    logic [31:0] word_codes;
    logic [31:0] word_pin;

    // read mux result and write strobes
    logic [31:0] rdata_d;
    logic        wr_tl;
    logic        wr_pin;

    // writes need byte lane zero, where every writable bit sits
    assign wr_tl  = cfg_req.wr && cfg_req.addr == off_tl_tuning && cfg_req.be[0];
    assign wr_pin = cfg_req.wr && cfg_req.addr == off_general_pin && cfg_req.be[0]
                    && is_upstream;

    // until the strap is captured the bit follows the pin, so no stale enable leaks out
    assign master_eff = strap_taken_q ? master_q : refclk_powerdown_strap;

    // tuning word: only the two writable bits take software data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tl_q <= tl_reset_val;
        end else if (dflt.load) begin
            tl_q <= dflt.tl_tuning & ~32'h4000_e000;
        end else if (wr_tl) begin
            tl_q <= (tl_q & ~tl_write_mask) | (cfg_req.wdata & tl_write_mask);
        end
    end

    // lane mode and global delta, read-only to software
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lane_q  <= lane_mode_reset;
            delta_q <= delta_reset;
        end else if (dflt.load) begin
            lane_q  <= dflt.lane_mode;
            delta_q <= dflt.delta;
        end
    end

    // transmit margin and receive equaliser; the equaliser exists upstream only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            margin_q <= tx_margin_reset;
            eq_q     <= is_upstream ? eq_reset_upstream : eq_reset_down;
        end else if (dflt.load) begin
            margin_q <= dflt.tx_margin;
            eq_q     <= is_upstream ? dflt.equaliser : eq_reset_down;
        end
    end

    // operation mode snapshot of the live mode inputs
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            opmode_q <= 16'h0000;
        end else begin
            opmode_q <= {7'd0, test_shift_mode, package_variant_select,
                         physical_layer_variant, debug_mode, fast_sim_mode,
                         quiescent_current_test_n, serial_rom_skip};
        end
    end

    // strap capture flag: the strap level only matters right after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_taken_q <= 1'b0;
        end else if (dflt.load || !strap_taken_q) begin
            strap_taken_q <= 1'b1;
        end
    end

    // master disable: strap first, then whatever a default load brings
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_q <= 1'b0; // constant in reset; master_eff covers the gap
        end else if (dflt.load) begin
            master_q <= dflt.refclk_master;
        end else if (!strap_taken_q) begin
            master_q <= refclk_powerdown_strap;
        end
    end

    // per-pair enables, reset to all enabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pairs_q <= refclk_pair_reset;
        end else if (dflt.load) begin
            pairs_q <= dflt.refclk_pairs;
        end
    end

    // next-capability pointer, loadable default
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            next_q <= cap_next_reset;
        end else if (dflt.load) begin
            next_q <= dflt.cap_next;
        end
    end

    // subsystem codes, read-only to software
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            vendor_q <= vendor_code_reset;
            device_q <= device_code_reset;
        end else if (dflt.load) begin
            vendor_q <= dflt.vendor_code;
            device_q <= dflt.device_code;
        end
    end

    // pin level sample; the pin is taken as synchronous to core_clk
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_in_q <= 1'b0;
        end else begin
            pin_in_q <= gpin0_in;
        end
    end

    // pin direction and output data, written by software
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_dir_q  <= 1'b0;
            pin_data_q <= 1'b0;
        end else if (wr_pin) begin
            pin_dir_q  <= cfg_req.wdata[pin_dir_bit];
            pin_data_q <= cfg_req.wdata[pin_data_bit];
        end
    end

    // read words; reserved positions are tied to zero here
    assign word_tl         = tl_q;
    assign word_lane_delta = {delta_q, 8'h00, lane_q};
    assign word_margin_eq  = {8'h00, eq_q, margin_q};
    assign word_opmode     = {11'h000, master_eff, pairs_q, opmode_q};
    assign word_cap        = {16'h0000, next_q, cap_id_subsys};
    assign word_codes      = {device_q, vendor_q};
    assign word_pin        = is_upstream ? {29'h0, pin_data_q, pin_dir_q, pin_in_q}
                                         : 32'h0000_0000;

    // read mux; unmapped offsets return zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (cfg_req.addr)
            off_tl_tuning:      rdata_d = word_tl;
            off_phy_lane_delta: rdata_d = word_lane_delta;
            off_phy_margin_eq:  rdata_d = word_margin_eq;
            off_opmode_refclk:  rdata_d = word_opmode;
            off_subsys_cap:     rdata_d = word_cap;
            off_subsys_codes:   rdata_d = word_codes;
            off_general_pin:    rdata_d = word_pin;
            default:            rdata_d = 32'h0000_0000;
        endcase
    end

    // acknowledge one cycle after any access
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ack <= 1'b0;
        end else begin
            cfg_ack <= cfg_req.rd | cfg_req.wr;
        end
    end

    // read data stands with the acknowledge only; writes answer with zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_rdata <= cfg_req.rd ? rdata_d : 32'h0000_0000;
        end
    end

    // pin zero drivers; oe_n low means the bank drives the pin
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gpin0_out  <= 1'b0;
            gpin0_oe_n <= 1'b1;
        end else begin
            gpin0_out  <= pin_dir_q & pin_data_q;
            gpin0_oe_n <= ~(pin_dir_q & is_upstream);
        end
    end

    // transaction-layer controls toward the port
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            relaxed_order_off        <= 1'b0;
            port_disabled            <= 1'b0;
            reset_select             <= 1'b0;
            rate_change_retry_select <= 2'b00;
        end else begin
            relaxed_order_off        <= tl_q[tl_order_dis_bit];
            port_disabled            <= tl_q[tl_port_dis_bit];
            reset_select             <= tl_q[tl_reset_sel_bit] & is_upstream;
            rate_change_retry_select <= tl_q[tl_retry_lsb +: 2];
        end
    end

    // clock pairs: the master disable overrides every per-pair enable
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            refclk_output_pairs <= 4'h0;
        end else begin
            refclk_output_pairs <= master_eff ? 4'h0 : pairs_q;
        end
    end

    // physical-layer settings toward the lanes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lane_mode                   <= 7'h00;
            multilane_receive_equaliser <= 8'h00;
        end else begin
            lane_mode                   <= lane_q;
            multilane_receive_equaliser <= eq_q;
        end
    end

endmodule // switch_port_vendor_config_regs
`default_nettype wire

// >>> tb/vendor_cfg_assertions.sv
// concurrent checks on the ports of the vendor config register bank
`timescale 1ns/1ps
`default_nettype none
module vendor_cfg_assertions
    import vendor_cfg_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset_n,
    // register access and default loads
    input wire cfg_req_type      cfg_req,
    input wire logic [31:0]      cfg_rdata,
    input wire logic             cfg_ack,
    input wire default_load_type dflt,
    // controls and pin
    input wire logic             relaxed_order_off,
    input wire logic [3:0]       refclk_output_pairs,
    input wire logic [6:0]       lane_mode,
    input wire logic [7:0]       multilane_receive_equaliser,
    input wire logic             gpin0_out,
    input wire logic             gpin0_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // a same-cycle load would move the outputs under the read, so reads with it are skipped
    logic rd_ok;
    assign rd_ok = cfg_req.rd && !dflt.load;

    ack_on_req_a: assert property ((cfg_req.rd || cfg_req.wr) |=> cfg_ack)
        else $error("no ack one cycle after a request");
    quiet_bus_a: assert property (!(cfg_req.rd || cfg_req.wr) |=> !cfg_ack && cfg_rdata == 32'h0)
        else $error("ack or read data without a request");
    order_write_a: assert property (cfg_req.wr && cfg_req.addr == off_tl_tuning && cfg_req.be[0]
        && !dflt.load |-> ##2 relaxed_order_off == $past(cfg_req.wdata[tl_order_dis_bit], 2))
        else $error("ordering control does not follow the write");
    tuning_read_a: assert property (rd_ok && cfg_req.addr == off_tl_tuning |=> cfg_rdata[15:13]
        == 3'h0 && !cfg_rdata[30] && cfg_rdata[tl_order_dis_bit] == relaxed_order_off)
        else $error("tuning word read wrong");
    cap_id_a: assert property (rd_ok && cfg_req.addr == off_subsys_cap |=>
        cfg_rdata[7:0] == cap_id_subsys && cfg_rdata[31:16] == 16'h0)
        else $error("capability id read wrong");
    lane_read_a: assert property (rd_ok && cfg_req.addr == off_phy_lane_delta |=>
        cfg_rdata[6:0] == lane_mode && cfg_rdata[14:7] == 8'h0)
        else $error("lane mode read wrong");
    equaliser_read_a: assert property (rd_ok && cfg_req.addr == off_phy_margin_eq |=>
        cfg_rdata[23:16] == multilane_receive_equaliser && cfg_rdata[31:24] == 8'h0)
        else $error("equaliser read wrong");
    refclk_pairs_a: assert property (rd_ok && cfg_req.addr == off_opmode_refclk |=>
        (cfg_rdata[20] ? refclk_output_pairs == 4'h0 : refclk_output_pairs == cfg_rdata[19:16])
        && cfg_rdata[31:21] == 11'h0)
        else $error("clock pair outputs disagree with buffer control");
    pin_drive_a: assert property (gpin0_out |-> !gpin0_oe_n)
        else $error("pin data shown while pin is an input");
endmodule // vendor_cfg_assertions

bind switch_port_vendor_config_regs vendor_cfg_assertions u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .dflt(dflt), .relaxed_order_off(relaxed_order_off),
    .refclk_output_pairs(refclk_output_pairs), .lane_mode(lane_mode),
    .multilane_receive_equaliser(multilane_receive_equaliser),
    .gpin0_out(gpin0_out), .gpin0_oe_n(gpin0_oe_n));
`default_nettype wire

// >>> tb/testbench.sv
// self-checking testbench for the vendor config register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vendor_cfg_pkg::*;
    localparam logic [15:0] ven_val = 16'h5a3c; // arbitrary value
    localparam logic [15:0] dev_val = 16'hc3a5; // arbitrary value
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    cfg_req_type cfg_req = '0;
    default_load_type dflt = '0;
    logic strap = 1'b1;
    logic ext_lvl = 1'b0;
    logic [8:0] md = 9'h1aa;
    logic [31:0] cfg_rdata, rd;
    logic cfg_ack, gpin0_out, gpin0_oe_n, ro_off, p_dis, r_sel;
    logic [1:0] retry;
    logic [3:0] pairs;
    logic [6:0] lane;
    logic [7:0] eq;
    wire logic pin_in;
    int err_total = 0;
    int compares = 0;

    always #25 core_clk = ~core_clk;
    // pin level: the bank when it drives, else the outside level
    assign pin_in = gpin0_oe_n ? ext_lvl : gpin0_out;

    switch_port_vendor_config_regs #(.is_upstream(1'b1)) DUT (
        .core_clk(core_clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .dflt(dflt), .refclk_powerdown_strap(strap),
        .test_shift_mode(md[8]), .package_variant_select(md[7:5]),
        .physical_layer_variant(md[4]), .debug_mode(md[3]), .fast_sim_mode(md[2]),
        .quiescent_current_test_n(md[1]), .serial_rom_skip(md[0]), .gpin0_in(pin_in),
        .gpin0_out(gpin0_out), .gpin0_oe_n(gpin0_oe_n), .relaxed_order_off(ro_off),
        .port_disabled(p_dis), .reset_select(r_sel), .rate_change_retry_select(retry),
        .refclk_output_pairs(pairs), .lane_mode(lane), .multilane_receive_equaliser(eq));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one access: request held for one edge, answer taken one cycle later
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cfg_req <= '{rd: !w, wr: w, addr: a, wdata: d, be: 4'h1};
        @(posedge core_clk);
        cfg_req <= '0;
        #1;
        chk("ack", 32'(cfg_ack), 32'h1);
        rd = cfg_rdata;
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask

    // outputs follow the registers one edge later: look after that edge
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        rchk("tuning", off_tl_tuning, 32'h0079_0010);
        rchk("lane_delta", off_phy_lane_delta, 32'h0000_8000);
        rchk("margin_eq", off_phy_margin_eq, 32'h0086_116b);
        rchk("opmode", off_opmode_refclk, 32'h001f_01aa);
        rchk("cap", off_subsys_cap, 32'h0000_c00d);
        rchk("codes_rst", off_subsys_codes, {device_code_reset, vendor_code_reset});
        rchk("pin", off_general_pin, 32'h0);
        rchk("unmapped", 8'hfc, 32'h0);
        chk("pairs", 32'(pairs), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_mode();
        @(posedge core_clk);
        md <= 9'h055;
        repeat (2) @(posedge core_clk);
        rchk("opmode2", off_opmode_refclk, 32'h001f_0055);
        $display("test mode done");
    endtask

    task automatic t_write();
        acc(1'b1, off_tl_tuning, 32'hffff_ffff);
        settle();
        chk("ro_off", 32'(ro_off), 32'h1);
        chk("port_dis", 32'(p_dis), 32'h0);
        rchk("tuning_wr", off_tl_tuning, 32'h0079_0070);
        acc(1'b1, off_phy_lane_delta, 32'hffff_ffff);
        rchk("lane_wr", off_phy_lane_delta, 32'h0000_8000);
        acc(1'b1, off_tl_tuning, 32'h0);
        settle();
        chk("ro_off_clr", 32'(ro_off), 32'h0);
        $display("test write done");
    endtask

    task automatic t_pin();
        acc(1'b1, off_general_pin, 32'h6);
        settle();
        chk("pin_drive", 32'({gpin0_oe_n, gpin0_out}), 32'h1);
        acc(1'b1, off_general_pin, 32'h4);
        settle();
        chk("pin_float", 32'({gpin0_oe_n, gpin0_out}), 32'h2);
        @(posedge core_clk);
        ext_lvl <= 1'b1;
        repeat (3) @(posedge core_clk);
        rchk("pin_in", off_general_pin, 32'h5);
        $display("test pin done");
    endtask

    task automatic t_load();
        @(posedge core_clk);
        dflt <= '{load: 1'b1, tl_tuning: 32'h0000_0f00, lane_mode: 7'h2a, delta: 17'h1_0000,
            tx_margin: 16'h1234, equaliser: 8'h3c, op_mode: 16'h0, refclk_pairs: 4'h5,
            refclk_master: 1'b0, cap_next: 8'h40, vendor_code: ven_val, device_code: dev_val};
        @(posedge core_clk);
        dflt.load <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("ctl", 32'({r_sel, p_dis, retry, pairs, lane, eq}), 32'h007a_aa3c);
        rchk("margin_ld", off_phy_margin_eq, 32'h003c_1234);
        rchk("tuning_ld", off_tl_tuning, 32'h0000_0f00);
        rchk("codes", off_subsys_codes, {dev_val, ven_val});
        rchk("cap_ld", off_subsys_cap, 32'h0000_400d);
        rchk("lane_ld", off_phy_lane_delta, 32'h8000_002a);
        rchk("refclk_ld", off_opmode_refclk, 32'h0005_0055);
        $display("test load done");
    endtask

    task automatic t_rst2();
        @(posedge core_clk);
        reset_n <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rchk("opmode_rst", off_opmode_refclk, 32'h000f_0055);
        chk("pairs_rst", 32'(pairs), 32'hf);
        rchk("pin_rst", off_general_pin, 32'h0000_0001);
        $display("test second reset done");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_mode();
        t_write();
        t_pin();
        t_load();
        t_rst2();
        report_and_stop();
    end

    // watchdog well past the fewer than a hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
